/* rtl/fixed_setpoint_selector.sv */
// Fixed setpoint selector: fifteen fixed values chosen by selection lines.
// Assumes inputs are synchronous to mclk_i and parameters are held stable
// by the controlling software between writes.
`timescale 1ns/10ps
`default_nettype none

module fixed_setpoint_selector #(
    parameter int VALUE_W = fixed_setpoint_pkg::VALUE_W,
    parameter int SLOTS   = fixed_setpoint_pkg::SLOTS,
    parameter int LINES   = fixed_setpoint_pkg::LINES
) (
    input  wire logic                 mclk_i,
    input  wire logic                 reset_i,
    // Fixed value programming
    input  wire logic                 value_wr_i,
    input  wire logic [3:0]           value_idx_i,
    input  wire logic [VALUE_W-1:0]   fixed_value_param_i,
    // Input function codes of lines one to four
    input  wire logic [4*8-1:0]       first_input_function_code_i,
    input  wire logic [2:0]           fixed_select_mode_i,
    // Selection line sources
    input  wire logic [LINES-1:0]     digital_lines_i,
    input  wire logic [LINES-1:0]     serial_lines_i,
    input  wire logic [LINES-1:0]     fixed_select_bit_source_i,
    // Setpoint routing
    input  wire logic                 source_wr_i,
    input  wire logic [3:0]           setpoint_source_select_i,
    input  wire logic                 pair_wr_i,
    input  wire logic [3:0]           source_pair_select_i,
    // Results
    output logic [VALUE_W-1:0]        fixed_setpoint_out_o,
    output logic                      run_cmd_o,
    output logic [15:0]               main_setpoint_route_o,
    output logic [15:0]               extra_setpoint_route_o,
    output logic [3:0]                pair_select_o
);

    // ****************************************************************
    // Local sizes
    // ****************************************************************
    localparam int IDX_W     = fixed_setpoint_pkg::IDX_W;
    localparam int CODE_W    = fixed_setpoint_pkg::CODE_W;
    localparam int BIN_LINES = fixed_setpoint_pkg::BIN_LINES;
    localparam int ROUTE_W   = fixed_setpoint_pkg::ROUTE_W;

    // ****************************************************************
    // Fixed value table
    // ****************************************************************
    logic [VALUE_W-1:0] fixed_speed_slot      [1:SLOTS];
    logic [VALUE_W-1:0] next_fixed_speed_slot [1:SLOTS];

    always_comb begin
        for (int i = 1; i <= SLOTS; i++) begin
            next_fixed_speed_slot[i] = fixed_speed_slot[i];
        end
        if (reset_i) begin
            for (int i = 1; i <= SLOTS; i++) begin
                next_fixed_speed_slot[i] = fixed_setpoint_pkg::ZERO_SPEED;
            end
        end else if (value_wr_i
                     && value_idx_i != fixed_setpoint_pkg::SLOT_NONE) begin
            next_fixed_speed_slot[value_idx_i] = fixed_value_param_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        for (int i = 1; i <= SLOTS; i++) begin
            fixed_speed_slot[i] <= next_fixed_speed_slot[i];
        end
    end

    // ****************************************************************
    // Selection
    // ****************************************************************
    // Per-line mux between terminal and serial source
    function automatic logic [LINES-1:0] pick_lines(
        input logic [LINES-1:0] dig,
        input logic [LINES-1:0] ser,
        input logic [LINES-1:0] src
    );
        pick_lines = (dig & ~src) | (ser & src);
    endfunction : pick_lines

    // Slot zero stands for the implicit zero speed entry
    function automatic logic [VALUE_W-1:0] slot_value(
        input logic [IDX_W-1:0] idx
    );
        if (idx == fixed_setpoint_pkg::SLOT_NONE) begin
            slot_value = fixed_setpoint_pkg::ZERO_SPEED;
        end else begin
            slot_value = fixed_speed_slot[idx];
        end
    endfunction : slot_value

    // Direct sum wraps silently; software must keep totals in range
    function automatic logic [VALUE_W-1:0] sum_selected(
        input logic [LINES-1:0] lines
    );
        logic [VALUE_W-1:0] acc;
        acc = fixed_setpoint_pkg::ZERO_SPEED;
        for (int i = 0; i < LINES; i++) begin
            if (lines[i]) begin
                acc = VALUE_W'(acc + slot_value(IDX_W'(i + 1)));
            end
        end
        sum_selected = acc;
    endfunction : sum_selected

    // Combined run needs every one of the first four lines set to binary
    function automatic logic codes_all_binary(
        input logic [BIN_LINES*CODE_W-1:0] codes
    );
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < BIN_LINES; i++) begin
            if (codes[i*CODE_W +: CODE_W]
                != fixed_setpoint_pkg::FUNC_BINARY_RUN) begin
                ok = 1'b0;
            end
        end
        codes_all_binary = ok;
    endfunction : codes_all_binary

    logic [LINES-1:0]        sel_lines;
    logic [VALUE_W-1:0]      sum_value;
    logic [VALUE_W-1:0]      bin_value;
    logic [IDX_W-1:0]        bin_index;
    logic                    bin_codes_ok;
    logic                    bin_active;
    logic                    any_line;
    logic [VALUE_W-1:0]      next_setpoint;
    logic                    next_run;
    fixed_setpoint_pkg::select_mode_e mode;

    // Selection decode: no state, shared by every mode
    always_comb begin
        sel_lines = pick_lines(digital_lines_i,
                               serial_lines_i,
                               fixed_select_bit_source_i);
        mode = fixed_setpoint_pkg::select_mode_e'(fixed_select_mode_i);
        sum_value = sum_selected(sel_lines);
        any_line = |sel_lines;
        bin_index = sel_lines[IDX_W-1:0];
        bin_value = slot_value(bin_index);
        bin_codes_ok = codes_all_binary(first_input_function_code_i);
        bin_active = (bin_index != fixed_setpoint_pkg::SLOT_NONE);
    end

    // Result per mode; an unknown mode code gives zero and no run
    always_comb begin
        next_setpoint = fixed_setpoint_pkg::ZERO_SPEED;
        next_run      = 1'b0;
        case (mode)
            fixed_setpoint_pkg::MODE_DIRECT: begin
                next_setpoint = sum_value;
            end
            fixed_setpoint_pkg::MODE_DIRECT_RUN: begin
                next_setpoint = sum_value;
                next_run      = any_line;
            end
            fixed_setpoint_pkg::MODE_BINARY_RUN: begin
                next_setpoint = bin_value;
                // Index zero is zero speed, so it never starts the drive
                next_run      = bin_codes_ok && bin_active;
            end
            default: begin
                next_setpoint = fixed_setpoint_pkg::ZERO_SPEED;
            end
        endcase
        if (reset_i) begin
            next_setpoint = fixed_setpoint_pkg::ZERO_SPEED;
            next_run      = 1'b0;
        end
    end

    // Sampled once per cycle, so output lags selection by one edge
    always_ff @(posedge mclk_i) begin
        fixed_setpoint_out_o <= next_setpoint;
        run_cmd_o            <= next_run;
    end

    // ****************************************************************
    // Setpoint routing
    // ****************************************************************
    // Other sources are not modelled, so they leave the main route empty
    function automatic logic [ROUTE_W-1:0] main_route_for(
        input logic [3:0] source
    );
        if (source == fixed_setpoint_pkg::SRC_FIXED) begin
            main_route_for = fixed_setpoint_pkg::ROUTE_FIXED;
        end else begin
            main_route_for = fixed_setpoint_pkg::ROUTE_NONE;
        end
    endfunction : main_route_for

    fixed_setpoint_pkg::route_pair_s route;
    fixed_setpoint_pkg::route_pair_s next_route;
    logic [3:0]                      next_pair;

    always_comb begin
        next_route = route;
        next_pair  = pair_select_o;
        if (reset_i) begin
            next_route.main_route  = fixed_setpoint_pkg::ROUTE_NONE;
            next_route.extra_route = fixed_setpoint_pkg::ROUTE_NONE;
            next_pair              = fixed_setpoint_pkg::PAIR_NONE;
        end else begin
            if (source_wr_i) begin
                // Both routes rewritten on every selector write
                next_route.extra_route = fixed_setpoint_pkg::ROUTE_NONE;
                next_route.main_route  =
                    main_route_for(setpoint_source_select_i);
            end
            if (pair_wr_i) begin
                next_pair = source_pair_select_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        route         <= next_route;
        pair_select_o <= next_pair;
    end

    always_ff @(posedge mclk_i) begin
        main_setpoint_route_o  <= next_route.main_route;
        extra_setpoint_route_o <= next_route.extra_route;
    end

endmodule : fixed_setpoint_selector

`default_nettype wire

/* rtl/fixed_setpoint_pkg.sv */
// Package for the fixed setpoint selector: widths, codes, modes, carriers.
// Assumes a single synchronous clock domain and no register bus.
package fixed_setpoint_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int VALUE_W   = 16;
    localparam int SLOTS     = 15;
    localparam int LINES     = 6;
    localparam int BIN_LINES = 4;

    // ****************************************************************
    // Input function codes and source selector codes
    // ****************************************************************
    localparam logic [7:0] FUNC_DIRECT     = 8'h0F;
    localparam logic [7:0] FUNC_DIRECT_RUN = 8'h10;
    localparam logic [7:0] FUNC_BINARY_RUN = 8'h11;
    localparam logic [7:0] FUNC_INTERCON   = 8'h63;
    localparam logic [3:0] SRC_FIXED       = 4'h3;

    // ****************************************************************
    // Field widths and empty codes
    // ****************************************************************
    localparam int         CODE_W          = 8;
    localparam int         IDX_W           = 4;
    localparam int         ROUTE_W         = 16;
    localparam logic [3:0] SLOT_NONE       = 4'h0;
    localparam logic [3:0] PAIR_NONE       = 4'h0;

    // ****************************************************************
    // Route codes and reset values
    // ****************************************************************
    localparam logic [15:0] ROUTE_NONE   = 16'h0000;
    localparam logic [15:0] ROUTE_FIXED  = 16'h0400;
    localparam logic [15:0] ZERO_SPEED   = 16'h0000;

    // Selection modes
    typedef enum logic [2:0] {
        MODE_DIRECT     = 3'b001,
        MODE_DIRECT_RUN = 3'b010,
        MODE_BINARY_RUN = 3'b100
    } select_mode_e;

    // Routing pair carried together
    typedef struct packed {
        logic [15:0] main_route;
        logic [15:0] extra_route;
    } route_pair_s;

endpackage : fixed_setpoint_pkg

/* verif/setpoint_source_model.sv */
// Model of the digital lines and the serial interface.
// Assumes sel_i holds the line levels that the controller intends.
`timescale 1ns/10ps
`default_nettype none
module setpoint_source_model (
    input  wire logic [5:0] sel_i,
    input  wire logic [5:0] src_i,
    output logic      [5:0] dig_o,
    output logic      [5:0] ser_o
);
    // Unused source shows the inverse, so a wrong pick is seen
    assign dig_o = sel_i ^ src_i;
    assign ser_o = sel_i ^ ~src_i;
endmodule : setpoint_source_model
`default_nettype wire

/* verif/setpoint_chk.sv */
// Port checker for the fixed setpoint selector.
// Assumes one clock and a synchronous reset; bound to the top module.
`timescale 1ns/10ps
`default_nettype none
module setpoint_chk #(parameter int LINES = 6) (
    input wire logic             mclk_i,
    input wire logic             reset_i,
    input wire logic [4*8-1:0]   first_input_function_code_i,
    input wire logic [2:0]       fixed_select_mode_i,
    input wire logic [LINES-1:0] digital_lines_i,
    input wire logic [LINES-1:0] serial_lines_i,
    input wire logic [LINES-1:0] fixed_select_bit_source_i,
    input wire logic             source_wr_i,
    input wire logic [3:0]       setpoint_source_select_i,
    input wire logic             pair_wr_i,
    input wire logic [3:0]       source_pair_select_i,
    input wire logic [15:0]      fixed_setpoint_out_o,
    input wire logic             run_cmd_o,
    input wire logic [15:0]      main_setpoint_route_o,
    input wire logic [15:0]      extra_setpoint_route_o,
    input wire logic [3:0]       pair_select_o
);
    wire logic [LINES-1:0] eff = (serial_lines_i & fixed_select_bit_source_i)
        | (digital_lines_i & ~fixed_select_bit_source_i);
    wire logic bin_ok = first_input_function_code_i ==
        {4{fixed_setpoint_pkg::FUNC_BINARY_RUN}};
    wire logic [2:0] md = fixed_select_mode_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    a_route_fixed: assert property (source_wr_i && setpoint_source_select_i ==
        4'h3 |=> main_setpoint_route_o == 16'h0400) else $error("main route");
    a_extra_zero: assert property (source_wr_i |=>
        extra_setpoint_route_o == 16'h0000) else $error("extra route");
    a_route_hold: assert property (!source_wr_i |=>
        $stable(main_setpoint_route_o)) else $error("route moved");
    a_pair_store: assert property (pair_wr_i |=> pair_select_o ==
        $past(source_pair_select_i)) else $error("pair store");
    a_direct_norun: assert property (md == 3'b001 |=> !run_cmd_o)
        else $error("direct run");
    a_direct_run: assert property (md == 3'b010 && |eff |=> run_cmd_o)
        else $error("no run");
    a_bin_run: assert property (md == 3'b100 && bin_ok && |eff[3:0] |=>
        run_cmd_o) else $error("binary run");
    a_bin_norun: assert property (md == 3'b100 && !bin_ok |=> !run_cmd_o)
        else $error("binary codes");
    a_zero_idle: assert property (md == 3'b001 && eff == '0 |=>
        fixed_setpoint_out_o == 16'h0000) else $error("idle value");
    a_bin_zero: assert property (md == 3'b100 && eff[3:0] == 4'h0 |=>
        fixed_setpoint_out_o == 16'h0000 && !run_cmd_o) else $error("code 0");
    c_direct: cover property (md == 3'b001 && &eff);
    c_binary: cover property (md == 3'b100 && bin_ok && eff[3:0] == 4'hF);
    c_route: cover property (source_wr_i && pair_wr_i);
endmodule : setpoint_chk
bind fixed_setpoint_selector setpoint_chk #(.LINES(LINES)) u_chk (.mclk_i,
    .reset_i, .first_input_function_code_i, .fixed_select_mode_i,
    .digital_lines_i, .serial_lines_i, .fixed_select_bit_source_i,
    .source_wr_i, .setpoint_source_select_i, .pair_wr_i,
    .source_pair_select_i, .fixed_setpoint_out_o, .run_cmd_o,
    .main_setpoint_route_o, .extra_setpoint_route_o, .pair_select_o);
`default_nettype wire

/* verif/fixed_setpoint_selector_bench.sv */
// Bench for the fixed setpoint selector, driven on the falling edge.
// Assumes the line model and the bound checker sit beside the design.
`timescale 1ns/10ps
`default_nettype none
module fixed_setpoint_selector_bench;
    logic        mclk_i, reset_i, value_wr_i, source_wr_i, pair_wr_i;
    logic [3:0]  value_idx_i, setpoint_source_select_i, source_pair_select_i;
    logic [15:0] fixed_value_param_i;
    logic [31:0] first_input_function_code_i;
    logic [2:0]  fixed_select_mode_i;
    logic [5:0]  fixed_select_bit_source_i, sel;
    wire  [5:0]  digital_lines_i, serial_lines_i;
    wire  [15:0] fixed_setpoint_out_o, main_setpoint_route_o;
    wire  [15:0] extra_setpoint_route_o;
    wire  [3:0]  pair_select_o;
    wire         run_cmd_o;
    int          fail_count, tests_run, cycles;
    fixed_setpoint_selector dut (.mclk_i, .reset_i, .value_wr_i, .value_idx_i,
        .fixed_value_param_i, .first_input_function_code_i,
        .fixed_select_mode_i, .digital_lines_i, .serial_lines_i,
        .fixed_select_bit_source_i, .source_wr_i, .setpoint_source_select_i,
        .pair_wr_i, .source_pair_select_i, .fixed_setpoint_out_o, .run_cmd_o,
        .main_setpoint_route_o, .extra_setpoint_route_o, .pair_select_o);
    setpoint_source_model lines (.sel_i(sel), .src_i(fixed_select_bit_source_i),
        .dig_o(digital_lines_i), .ser_o(serial_lines_i));
    task automatic print_verdict;
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic step;
        @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : step
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic pick(input logic [2:0] mode, input logic [5:0] l);
        fixed_select_mode_i = mode;
        sel = l;
        step;
    endtask : pick
    initial begin
        mclk_i = 0;
        forever #25 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict;
        end
    end
    initial begin
        {value_wr_i, source_wr_i, pair_wr_i, value_idx_i} = '0;
        {setpoint_source_select_i, source_pair_select_i, sel} = '0;
        {fixed_value_param_i, fixed_select_bit_source_i} = '0;
        first_input_function_code_i = {4{8'h11}};
        fixed_select_mode_i = 3'b001;
        reset_i = 1;
        repeat (8) @(negedge mclk_i);
        reset_i = 0;
        check(fixed_setpoint_out_o, 16'h0000);
        for (int k = 0; k < 16; k++) begin
            value_idx_i = k[3:0];
            fixed_value_param_i = (k == 0) ? 16'hFFFF : 16'(k) * 16'h0011;
            value_wr_i = 1;
            step;
            value_wr_i = 0;
        end
        pick(3'b001, 6'h00);
        check(fixed_setpoint_out_o, 16'h0000);
        for (int n = 0; n < 6; n++) begin
            pick(3'b001, 6'(1 << n));
            check(fixed_setpoint_out_o, 16'(n + 1) * 16'h0011);
        end
        pick(3'b001, 6'h3F);
        check(fixed_setpoint_out_o, 16'h0165);
        check({15'h0, run_cmd_o}, 16'h0000);
        pick(3'b010, 6'h05);
        check(fixed_setpoint_out_o, 16'h0044);
        check({15'h0, run_cmd_o}, 16'h0001);
        for (int k = 0; k < 16; k++) begin
            pick(3'b100, {2'b11, k[3:0]});
            check(fixed_setpoint_out_o, 16'(k) * 16'h0011);
            check({15'h0, run_cmd_o}, 16'(k != 0));
        end
        first_input_function_code_i[31:24] = 8'h0F;
        pick(3'b100, 6'h01);
        check({15'h0, run_cmd_o}, 16'h0000);
        fixed_select_bit_source_i = 6'h3F;
        pick(3'b001, 6'h02);
        check(fixed_setpoint_out_o, 16'h0022);
        {source_wr_i, setpoint_source_select_i} = {1'b1, 4'h3};
        step;
        check(main_setpoint_route_o, 16'h0400);
        check(extra_setpoint_route_o, 16'h0000);
        {source_wr_i, pair_wr_i, source_pair_select_i} = {2'b01, 4'h5};
        step;
        check({12'h000, pair_select_o}, 16'h0005);
        check(main_setpoint_route_o, 16'h0400);
        {source_wr_i, pair_wr_i, setpoint_source_select_i} = {2'b10, 4'h1};
        step;
        check(main_setpoint_route_o, 16'h0000);
        print_verdict;
    end
endmodule : fixed_setpoint_selector_bench
`default_nettype wire
